// >>> rtl/pio_host_ctrl.sv
// host controller that runs transfer instructions on the parallel port bus
`timescale 1ns/100ps
`default_nettype none

module pio_host_ctrl
   import pio_pkg::*;
#(
   parameter int CNT_W = 4  // sequencer counter width
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // software register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [BUS_W-1:0]  wr_data,
   input  wire logic              wr_strobe,
   input  wire logic              rd_strobe,
   output logic      [BUS_W-1:0]  rd_data,
   // device bus
   output logic                   addr_latch_strobe,
   output logic                   dev_select_strobe,
   input  wire logic [BUS_W-1:0]  shared_bus_in,
   output logic      [BUS_W-1:0]  shared_bus_out,
   output logic                   shared_bus_oe,
   input  wire logic              xfer_indicate_n,
   input  wire logic              skip_irq_n,
   // chip select straps for the device
   output logic                   chip_sel_hi,
   output logic                   chip_sel_lo
);

   // refuse a counter too narrow for the longest wait
   if (RD_CYC >= (1 << CNT_W) || CNT_W < 2) begin : g_chk
      $error("pio_host_ctrl: CNT_W too small for timing counts");
   end

   // reset release, second stage is the only user copy
   logic [1:0]       rst_sync_reg;
   wire              rst_n = rst_sync_reg[1];

   // sequencer state
   pio_state_e       state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   // software visible state
   logic [BUS_W-1:0] acc_reg, acc_next;
   logic [3:0]       ctl_reg;
   logic [1:0]       dev_reg;
   logic             skip_reg, xfer_reg, irq_reg;
   // registered pin images
   logic             latch_reg, dev_select_strobe_reg, oe_reg;
   logic [BUS_W-1:0] bus_reg, rd_data_reg;
   logic             csh_reg, csl_reg;

   // cycle count loaded on entry to a state
   function automatic logic [CNT_W-1:0] dwell(input pio_state_e s);
      int n;
      case (s)
         S_ADDR:  n = ADDR_CYC;
         S_HOLD:  n = HOLD_CYC;
         S_READ:  n = RD_CYC;
         S_WSET:  n = WSET_CYC;
         S_WRITE: n = WSET_CYC;
         S_WHOLD: n = WHOLD_CYC;
         default: n = GAP_CYC;
      endcase
      return CNT_W'(n - 1);
   endfunction

   // register port decode
   wire busy       = (state_reg != S_IDLE);
   wire launch     = wr_strobe && (addr == REG_CTRL) && !busy;
   wire acc_wr     = wr_strobe && (addr == REG_ACC) && !busy;
   wire dev_wr     = wr_strobe && (addr == REG_DEVNUM) && !busy;
   wire last       = (cnt_reg == '0);
   wire rd_sample  = (state_reg == S_READ) && last;  // end of read pulse
   wire responded  = !xfer_indicate_n;
   // instruction word: opcode, fixed pattern, device, control code
   wire [BUS_W-1:0] iot_word = {IOT_OPCODE, DEV_PATTERN, dev_reg, ctl_reg};
   wire [3:0]  status_word = {irq_reg, xfer_reg, skip_reg, busy};
   wire [BUS_W-1:0] rd_mux =
      (addr == REG_ACC)    ? acc_reg :
      (addr == REG_STATUS) ? {8'h00, status_word} :
      (addr == REG_DEVNUM) ? {10'h000, dev_reg} :
      (addr == REG_CTRL)   ? {8'h00, ctl_reg} : 12'h000;

   // sequencer: one latch, then read pulse, then write pulse
   always_comb begin
      state_next = state_reg;
      cnt_next   = last ? cnt_reg : cnt_reg - 1'b1;
      case (state_reg)
         S_IDLE:  if (launch) state_next = S_ADDR;
         S_ADDR:  if (last) state_next = S_HOLD;
         S_HOLD:  if (last) state_next = S_GAP1;
         S_GAP1:  if (last) state_next = S_READ;
         S_READ:  if (last) state_next = S_GAP2;
         S_GAP2:  if (last) state_next = S_WSET;
         S_WSET:  if (last) state_next = S_WRITE;
         S_WRITE: if (last) state_next = S_WHOLD;
         S_WHOLD: if (last) state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
      if (state_next != state_reg) begin
         cnt_next = dwell(state_next);
      end
   end

   // accumulator: software load, or OR merge of read data
   always_comb begin
      acc_next = acc_reg;
      if (acc_wr) begin
         acc_next = wr_data;
      end else if (rd_sample && responded) begin
         acc_next = acc_reg | shared_bus_in;
      end
   end

   // pin images follow the next state so pins change with it
   wire addr_ph = (state_next == S_ADDR) || (state_next == S_HOLD);
   wire wr_ph   = (state_next == S_WSET) || (state_next == S_WRITE) ||
                  (state_next == S_WHOLD);
   wire sel_low = (state_next == S_READ) || (state_next == S_WRITE);

   // reset release chain
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) rst_sync_reg <= 2'b00;
      else          rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   // sequencer and accumulator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         cnt_reg   <= '0;
         acc_reg   <= ACC_RST;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         acc_reg   <= acc_next;
      end
   end

   // software settings and sampled status
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg  <= 4'h0;
         dev_reg  <= DEVNUM_RST;
         skip_reg <= 1'b0;
         xfer_reg <= 1'b0;
         irq_reg  <= 1'b0;
      end else begin
         if (launch) ctl_reg <= wr_data[3:0];
         if (dev_wr) dev_reg <= wr_data[1:0];
         // flags cleared on launch, set only at the read sample
         if (rd_sample)   skip_reg <= !skip_irq_n;
         else if (launch) skip_reg <= 1'b0;
         if (rd_sample)   xfer_reg <= responded;
         else if (launch) xfer_reg <= 1'b0;
         // line means interrupt only while select is high
         if (dev_select_strobe_reg) irq_reg <= !skip_irq_n;
      end
   end

   // registered pin drive; bus released whenever the device may drive
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_reg   <= 1'b0;
         dev_select_strobe_reg  <= 1'b1;
         oe_reg      <= 1'b0;
         bus_reg     <= 12'h000;
         rd_data_reg <= 12'h000;
         csh_reg     <= 1'b0;
         csl_reg     <= 1'b0;
      end else begin
         latch_reg   <= (state_next == S_ADDR);
         dev_select_strobe_reg  <= !sel_low;
         oe_reg      <= addr_ph || wr_ph;
         bus_reg     <= addr_ph ? iot_word : acc_reg;
         if (rd_strobe) rd_data_reg <= rd_mux;
         csh_reg     <= dev_reg[1];
         csl_reg     <= dev_reg[0];
      end
   end

   assign rd_data           = rd_data_reg;
   assign addr_latch_strobe = latch_reg;
   assign dev_select_strobe = dev_select_strobe_reg;
   assign shared_bus_out    = bus_reg;
   assign shared_bus_oe     = oe_reg;
   assign chip_sel_hi       = csh_reg;
   assign chip_sel_lo       = csl_reg;

   // checks on the driven bus sequence
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_addr_at_latch: assert property ($fell(latch_reg) |->
      oe_reg && bus_reg[PAT_LSB +: 3] == DEV_PATTERN)
      else $error("address pattern not on bus at latch fall");
   a_dev_at_latch: assert property ($fell(latch_reg) |->
      bus_reg[DEV_LSB +: 2] == {csh_reg, csl_reg})
      else $error("device bits differ from chip selects");
   a_latch_hold: assert property ($fell(latch_reg) |->
      (oe_reg && $stable(bus_reg)) [*3])
      else $error("address not held after latch fall");
   a_read_release: assert property (state_reg == S_READ |-> !oe_reg)
      else $error("bus driven during read pulse");
   a_acc_merge: assert property (rd_sample && responded && !acc_wr |=>
      acc_reg == ($past(acc_reg) | $past(shared_bus_in)))
      else $error("read data not merged into accumulator");
   a_write_data: assert property ($rose(dev_select_strobe_reg) && state_reg == S_WHOLD |->
      oe_reg && bus_reg == acc_reg)
      else $error("write data missing at select rise");
   a_pulse_order: assert property ($fell(latch_reg) |->
      ##[1:20] (!dev_select_strobe_reg && state_reg == S_READ) ##[1:40] $fell(dev_select_strobe_reg))
      else $error("read and write pulses not in order");
   a_no_overlap: assert property (!dev_select_strobe_reg |-> !latch_reg)
      else $error("select low while latch high");

   c_read_merge: cover property (rd_sample && responded);
   c_skip_seen:  cover property (rd_sample && !skip_irq_n);
   c_irq_seen:   cover property (dev_select_strobe_reg && !skip_irq_n && !busy);
   c_back2back:  cover property (state_reg == S_WHOLD && last ##1 launch);

endmodule

`default_nettype wire

// >>> rtl/pio_pkg.sv
// constants, timing counts and types shared by the parallel port host controller
package pio_pkg;
   // clock and bus timing, figures in ns
   localparam int CLK_PERIOD_NS   = 40;
   localparam int T_ADDR_SETUP_NS = 80;   // bus valid before latch falls
   localparam int T_ADDR_HOLD_NS  = 100;  // bus held after latch falls
   localparam int T_RD_ENABLE_NS  = 450;  // select low to read data valid
   localparam int T_DATA_SETUP_NS = 150;  // write data before select rises
   localparam int T_DATA_HOLD_NS  = 100;  // write data after select rises
   localparam int T_GAP_NS        = 80;   // quiet time between strobes

   // least time to whole cycles, never under one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int ADDR_CYC  = ns_to_cyc(T_ADDR_SETUP_NS);
   localparam int HOLD_CYC  = ns_to_cyc(T_ADDR_HOLD_NS);
   localparam int RD_CYC    = ns_to_cyc(T_RD_ENABLE_NS);
   localparam int WSET_CYC  = ns_to_cyc(T_DATA_SETUP_NS);
   localparam int WHOLD_CYC = ns_to_cyc(T_DATA_HOLD_NS);
   localparam int GAP_CYC   = ns_to_cyc(T_GAP_NS);

   // transfer instruction word layout
   localparam int         BUS_W       = 12;
   localparam int         OPC_LSB     = 9;
   localparam int         PAT_LSB     = 6;
   localparam int         DEV_LSB     = 4;
   localparam int         CTL_LSB     = 0;
   localparam logic [2:0] IOT_OPCODE  = 3'h6;
   localparam logic [2:0] DEV_PATTERN = 3'h3;

   // software register map, word indices
   localparam int         ADDR_W     = 4;
   localparam logic [3:0] REG_CTRL   = 4'h0;  // write: launch, bits 3:0 control code
   localparam logic [3:0] REG_ACC    = 4'h1;  // accumulator
   localparam logic [3:0] REG_STATUS = 4'h2;  // read only
   localparam logic [3:0] REG_DEVNUM = 4'h3;  // bits 1:0 device number

   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_SKIP = 1;
   localparam int ST_XFER = 2;
   localparam int ST_IRQ  = 3;

   // reset values
   localparam logic [11:0] ACC_RST    = 12'h000;
   localparam logic [1:0]  DEVNUM_RST = 2'h0;

   // transfer sequencer states
   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_HOLD, S_GAP1, S_READ, S_GAP2, S_WSET, S_WRITE, S_WHOLD
   } pio_state_e;
endpackage

// >>> test/pio_dev_model.sv
// behavioural model of the parallel port device on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module pio_dev_model (
   // strobes and straps from the host
   input  wire logic        addr_latch_strobe,
   input  wire logic        dev_select_strobe,
   input  wire logic        chip_sel_hi,
   input  wire logic        chip_sel_lo,
   // resolved bus and this device's drive onto it
   input  wire logic [11:0] shared_bus,
   output logic      [11:0] dev_bus_out,
   output logic             dev_bus_oe,
   output logic             xfer_pull,
   output logic             skip_irq_n,
   // peripheral pins and scenario knobs
   input  wire logic [11:0] port_in,
   input  wire logic        skip_cond,
   input  wire logic        irq_pend,
   output logic      [11:0] port_out
);
   logic [11:0] word_reg;  // latched instruction word
   logic [11:0] in_latch;  // pins sampled at latch fall
   logic [1:0]  pulses;    // select pulses since latch
   wire         hit;       // device addressed
   wire         rd_phase;  // first select pulse
   // power-on: all ports inputs, nothing stored
   initial begin
      word_reg = '0;
      in_latch = '0;
      pulses = '0;
      port_out = '0;
   end
   // address and pin capture on latch fall
   always @(negedge addr_latch_strobe) begin
      word_reg = shared_bus;
      in_latch = port_in;
      pulses = 2'h0;
   end
   // count select pulses, saturating
   always @(negedge dev_select_strobe) begin
      if (pulses != 2'h3) pulses = pulses + 2'h1;
   end
   // second pulse stores bus data on its rise, code 2 only
   always @(posedge dev_select_strobe) begin
      if (hit && pulses == 2'h2 && word_reg[3:0] == 4'h2) port_out = shared_bus;
   end
   assign hit = word_reg[11:9] == 3'h6 && word_reg[8:6] == 3'h3
                && word_reg[5:4] == {chip_sel_hi, chip_sel_lo};
   assign rd_phase = hit && !dev_select_strobe && pulses == 2'h1;
   // read code 1 drives data and pulls the indicate line
   assign dev_bus_oe = rd_phase && word_reg[3:0] == 4'h1;
   assign dev_bus_out = in_latch;
   assign xfer_pull = rd_phase && word_reg[3:0] == 4'h1;
   // skip during read pulse, interrupt status otherwise
   assign skip_irq_n = rd_phase ? !(word_reg[3:0] == 4'h3 && skip_cond) : !irq_pend;
endmodule
`default_nettype wire

// >>> test/test_pio_host_ctrl.sv
// self-checking bench for the parallel port host controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_pio_host_ctrl;
   import pio_pkg::*;
   // one row: inputs, then expected acc and status
   typedef struct {
      logic [1:0] dev; logic [3:0] ctl; logic [11:0] acc; logic [11:0] port;
      logic skp; logic irq; logic [11:0] eacc; logic [3:0] est;
   } pio_row_s;
   pio_row_s rows [7] = '{
      '{2'h0, 4'h1, 12'h0F0, 12'h00F, 1'b0, 1'b0, 12'h0FF, 4'h4},
      '{2'h2, 4'h2, 12'hA5C, 12'hFFF, 1'b0, 1'b0, 12'hA5C, 4'h0},
      '{2'h3, 4'h3, 12'h123, 12'h000, 1'b1, 1'b0, 12'h123, 4'h2},
      '{2'h1, 4'h3, 12'h800, 12'h000, 1'b0, 1'b0, 12'h800, 4'h0},
      '{2'h1, 4'h1, 12'h800, 12'h801, 1'b0, 1'b1, 12'h801, 4'hC},
      '{2'h3, 4'h0, 12'hFFF, 12'h000, 1'b0, 1'b1, 12'hFFF, 4'h8},
      '{2'h3, 4'h2, 12'h000, 12'h000, 1'b0, 1'b0, 12'h000, 4'h0}};
   logic clk, reset_n, wr_strobe, rd_strobe, skip_cond, irq_pend;
   logic [3:0] addr;
   logic [11:0] wr_data, rd_data, shared_bus_in, shared_bus_out, port_in, port_out, d, pexp;
   logic [11:0] dev_out;
   logic [11:0] cyc = '0;  // released-bus pattern source
   logic addr_latch_strobe, dev_select_strobe, shared_bus_oe, xfer_indicate_n, skip_irq_n;
   logic chip_sel_hi, chip_sel_lo, dev_oe, xfer_pull;
   int err_count = 0;
   int compares = 0;
   pio_host_ctrl #(.CNT_W(4)) i_pio_host_ctrl (.clk, .reset_n, .addr, .wr_data, .wr_strobe,
      .rd_strobe, .rd_data, .addr_latch_strobe, .dev_select_strobe, .shared_bus_in,
      .shared_bus_out, .shared_bus_oe, .xfer_indicate_n, .skip_irq_n, .chip_sel_hi, .chip_sel_lo);
   pio_dev_model i_pio_dev_model (.addr_latch_strobe, .dev_select_strobe, .chip_sel_hi,
      .chip_sel_lo, .shared_bus(shared_bus_in), .dev_bus_out(dev_out), .dev_bus_oe(dev_oe),
      .xfer_pull, .skip_irq_n, .port_in, .skip_cond, .irq_pend, .port_out);
   // nobody driving: a changing pattern, so stale data never passes
   always @(posedge clk) cyc <= cyc + 12'h001;
   assign shared_bus_in = shared_bus_oe ? shared_bus_out : (dev_oe ? dev_out : ~cyc);
   assign xfer_indicate_n = xfer_pull ? 1'b0 : 1'b1;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // register write, gap cycle before it avoids double assignment
   task automatic wr(input logic [3:0] a, input logic [11:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_strobe <= 1'b1;
      @(posedge clk);
      wr_strobe <= 1'b0;
   endtask
   // register read, data taken in the one cycle it stands
   task automatic rd(input logic [3:0] a, output logic [11:0] v);
      @(posedge clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1 v = rd_data;
   endtask
   // launch, poke a register while busy, then poll until done
   task automatic run(input logic [3:0] c, input logic [3:0] a, input logic [11:0] v);
      int n;
      logic [11:0] s;
      wr(REG_CTRL, {8'h00, c});
      wr(a, v);
      n = 0;
      s = 12'h001;
      while (s[ST_BUSY] !== 1'b0 && n < 100) begin
         rd(REG_STATUS, s);
         n++;
      end
      `CHK(n < 100, 1'b1)
   endtask
   task automatic finish_test;
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // hang guard, well past the expected few hundred cycles
   initial begin
      repeat (8000) @(posedge clk);
      err_count++;
      finish_test;
   end
   initial begin
      {reset_n, wr_strobe, rd_strobe, skip_cond, irq_pend} = '0;
      {addr, wr_data, port_in} = '0;
      pexp = 12'h000;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      // table rows; a read-only status write rides along while busy
      foreach (rows[i]) begin
         port_in <= rows[i].port;
         skip_cond <= rows[i].skp;
         irq_pend <= rows[i].irq;
         wr(REG_DEVNUM, {10'h000, rows[i].dev});
         wr(REG_ACC, rows[i].acc);
         run(rows[i].ctl, REG_STATUS, 12'hFFF);
         if (rows[i].ctl == 4'h2) pexp = rows[i].acc;
         `CHK({chip_sel_hi, chip_sel_lo}, rows[i].dev)
         rd(REG_ACC, d);
         `CHK(d, rows[i].eacc)
         rd(REG_STATUS, d);
         `CHK(d[3:0], rows[i].est)
         `CHK(port_out, pexp)
         rd(REG_CTRL, d);
         `CHK(d[3:0], rows[i].ctl)
      end
      // accumulator write during a transfer is dropped
      wr(REG_ACC, 12'h3C3);
      run(4'h2, REG_ACC, 12'h111);
      rd(REG_ACC, d);
      `CHK(d, 12'h3C3)
      `CHK(port_out, 12'h3C3)
      // unmapped index reads zero
      wr(4'hF, 12'hFFF);
      rd(4'hF, d);
      `CHK(d, 12'h000)
      // second reset while idle, after the last transfer
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK({chip_sel_hi, chip_sel_lo, shared_bus_oe, dev_select_strobe, addr_latch_strobe}, 5'h02)
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(REG_ACC, d);
      `CHK(d, ACC_RST)
      rd(REG_DEVNUM, d);
      `CHK(d[1:0], DEVNUM_RST)
      rd(REG_STATUS, d);
      `CHK(d, 12'h000)
      rd(REG_CTRL, d);
      `CHK(d, 12'h000)
      finish_test;
   end
endmodule
`default_nettype wire
